// ==== shared/e8tc_regs.vh ====
// Register map, field positions, reset values and timing counts of the 8-bit timer control
`ifndef E8TC_REGS_VH
`define E8TC_REGS_VH
// ************************************************
// Register byte addresses
// ************************************************
`define E8TC_ADDR_CONTROL   12'hd00
`define E8TC_ADDR_LOW_HOLD  12'hd04
`define E8TC_ADDR_INT_STAT  12'hd08
`define E8TC_ADDR_INT_MASK  12'hd0c
`define E8TC_ADDR_COUNT     12'hd10
// ************************************************
// Control fields
// ************************************************
`define E8TC_CTL_ON         7
`define E8TC_CTL_ONESHOT    6
`define E8TC_CTL_FLAG       5
`define E8TC_CTL_PSC_HI     4
`define E8TC_CTL_PSC_LO     3
`define E8TC_CTL_CAP_MASK   2
`define E8TC_CTL_TMO_MASK   1
`define E8TC_CTL_PIN_SEL    0
// ************************************************
// Reset values and bus answers
// ************************************************
`define E8TC_CONTROL_RST    8'h00
`define E8TC_LOW_HOLD_RST   8'h00
`define E8TC_INT_RST        1'h0
`define E8TC_RESP_OKAY      2'h0
`define E8TC_RESP_SLVERR    2'h2
// ************************************************
// Prescale codes and divider width
// ************************************************
`define E8TC_PSC_DIV1       2'h0
`define E8TC_PSC_DIV2       2'h1
`define E8TC_PSC_DIV4       2'h2
`define E8TC_PSC_DIV8       2'h3
`define E8TC_PSC_W          3
`endif

// ==== core/e8tc_prescaler.v ====
// Counter clock enable divider for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "e8tc_regs.vh"
module e8tc_prescaler
(
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [1:0] prescale_select,
  output reg        tick
);
  reg [`E8TC_PSC_W-1:0] div_reg;
  reg                   hit;

  // ************************************************
  // Divider
  // ************************************************
  always @*
  begin
    case (prescale_select)
      `E8TC_PSC_DIV1: hit = 1'b1;
      `E8TC_PSC_DIV2: hit = div_reg[0];
      `E8TC_PSC_DIV4: hit = &div_reg[1:0];
      `E8TC_PSC_DIV8: hit = &div_reg;
      default:        hit = 1'b1;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_reg <= {`E8TC_PSC_W{1'b0}};
      tick    <= 1'b0;
    end
    else
    begin
      div_reg <= div_reg + {{(`E8TC_PSC_W-1){1'b0}}, 1'b1};
      tick    <= hit;
    end
  end
endmodule // e8tc_prescaler
`default_nettype wire

// ==== core/e8tc_top.v ====
// 8-bit timer control and status with an AXI4-Lite register slave
// Behaviour
// - Terminal-count flag, control bit 5, clears only on a written one.
// - Writing back a read 1 to bit 5 clears flag and resets timer.
// - Control bits: on 7, mode 6, flag 5, prescale 4:3, masks 2:1, pin 0.
// - Control register at D00h, all bits zero after reset.
// - Low-hold register holds the count loaded at every start and reload, at either output level.
// - Flag sets whenever the counter reaches terminal count.
// - Prescale 00 undivided, 01 by 2, 10 by 4, 11 by 8.
// - Mode 0 reloads at terminal count, mode 1 stops there.
`timescale 1ns/1ps
`default_nettype none
`include "e8tc_regs.vh"
module e8tc_top
#(
  parameter ADDR_W = 12
)
(
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg               irq,
  output reg               timer_out,
  output reg               timer_pin_oe
);
  // ************************************************
  // State
  // ************************************************
  reg [7:0]        control_reg;
  reg [7:0]        low_phase_hold_reg;
  reg [7:0]        count_reg;
  reg              running_reg;
  reg              int_stat_reg;
  reg              int_mask_reg;
  reg              aw_held_reg;
  reg              w_held_reg;
  reg [ADDR_W-1:0] aw_addr_reg;
  reg [7:0]        w_data_reg;
  reg              w_lane_reg;
  wire             tick;
  wire             wr_go;
  wire             wr_ok;
  wire             wr_ctl;
  wire             flag_clr;
  wire             tc_event;
  wire             start;
  wire             psc_hit;

  function is_mapped;
    input [ADDR_W-1:0] a;
    begin
      is_mapped = (a == `E8TC_ADDR_CONTROL) || (a == `E8TC_ADDR_LOW_HOLD) ||
                  (a == `E8TC_ADDR_INT_STAT) || (a == `E8TC_ADDR_INT_MASK) ||
                  (a == `E8TC_ADDR_COUNT);
    end
  endfunction

  // ************************************************
  // Prescaler
  // ************************************************
  e8tc_prescaler u_prescaler
  (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .prescale_select (control_reg[`E8TC_CTL_PSC_HI:`E8TC_CTL_PSC_LO]),
    .tick            (tick)
  );

  // ************************************************
  // Write channel
  // ************************************************
  // Address and data are taken independently and joined once both are held
  assign wr_go    = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_ok    = wr_go && w_lane_reg;
  assign wr_ctl   = wr_ok && (aw_addr_reg == `E8TC_ADDR_CONTROL);
  assign flag_clr = wr_ctl && w_data_reg[`E8TC_CTL_FLAG];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= {ADDR_W{1'b0}};
      w_data_reg    <= 8'h00;
      w_lane_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `E8TC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr_reg) ? `E8TC_RESP_OKAY : `E8TC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************
  // Registers
  // ************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg        <= `E8TC_CONTROL_RST;
      low_phase_hold_reg <= `E8TC_LOW_HOLD_RST;
      int_mask_reg       <= `E8TC_INT_RST;
    end
    else
    begin
      if (wr_ctl)
      begin
        // Flag bit is never stored from the bus
        control_reg[7:6] <= w_data_reg[7:6];
        control_reg[4:0] <= w_data_reg[4:0];
      end
      // Set wins over a clear in the same cycle
      control_reg[`E8TC_CTL_FLAG] <= tc_event | (control_reg[`E8TC_CTL_FLAG] & ~flag_clr);
      if (wr_ok && (aw_addr_reg == `E8TC_ADDR_LOW_HOLD))
      begin
        low_phase_hold_reg <= w_data_reg;
      end
      if (wr_ok && (aw_addr_reg == `E8TC_ADDR_INT_MASK))
      begin
        int_mask_reg <= w_data_reg[0];
      end
    end
  end

  // ************************************************
  // Counter
  // ************************************************
  // A rising enable or a flag clear reloads the count, the timer reset condition
  assign start    = (wr_ctl && w_data_reg[`E8TC_CTL_ON] && !control_reg[`E8TC_CTL_ON]) || flag_clr;
  assign psc_hit  = tick && running_reg && control_reg[`E8TC_CTL_ON];
  assign tc_event = psc_hit && (count_reg == 8'h00);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg   <= 8'h00;
      running_reg <= 1'b0;
      timer_out   <= 1'b0;
    end
    else if (start)
    begin
      count_reg   <= low_phase_hold_reg;
      running_reg <= 1'b1;
      timer_out   <= 1'b0;
    end
    else if (tc_event)
    begin
      timer_out <= ~timer_out;
      if (control_reg[`E8TC_CTL_ONESHOT])
      begin
        running_reg <= 1'b0;
      end
      else
      begin
        count_reg <= low_phase_hold_reg;
      end
    end
    else if (psc_hit)
    begin
      count_reg <= count_reg - 8'h01;
    end
  end

  // ************************************************
  // Interrupt
  // ************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_stat_reg <= `E8TC_INT_RST;
      irq          <= 1'b0;
      timer_pin_oe <= 1'b0;
    end
    else
    begin
      // Set wins over a write-one clear
      int_stat_reg <= (tc_event && control_reg[`E8TC_CTL_TMO_MASK]) |
                      (int_stat_reg & ~(wr_ok && (aw_addr_reg == `E8TC_ADDR_INT_STAT) && w_data_reg[0]));
      irq          <= int_stat_reg & int_mask_reg;
      timer_pin_oe <= control_reg[`E8TC_CTL_PIN_SEL];
    end
  end

  // ************************************************
  // Read channel
  // ************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `E8TC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= is_mapped(s_axi_araddr) ? `E8TC_RESP_OKAY : `E8TC_RESP_SLVERR;
        case (s_axi_araddr)
          `E8TC_ADDR_CONTROL:  s_axi_rdata <= {24'h000000, control_reg};
          `E8TC_ADDR_LOW_HOLD: s_axi_rdata <= {24'h000000, low_phase_hold_reg};
          `E8TC_ADDR_INT_STAT: s_axi_rdata <= {31'h00000000, int_stat_reg};
          `E8TC_ADDR_INT_MASK: s_axi_rdata <= {31'h00000000, int_mask_reg};
          `E8TC_ADDR_COUNT:    s_axi_rdata <= {23'h000000, running_reg, count_reg};
          default:             s_axi_rdata <= 32'h00000000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // e8tc_top
`default_nettype wire

// ==== bench/e8tc_monitor.sv ====
// Port checker for the 8-bit timer control
`timescale 1ns/1ps
`default_nettype none
`include "e8tc_regs.vh"
module e8tc_monitor #(parameter ADDR_W = 12)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              timer_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer changed early");
  property p_ar_off; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_off: assert property (p_ar_off) else $error("read taken while answer pending");
  property p_aw_off; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_off: assert property (p_aw_off) else $error("write taken while answer pending");
  property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("write answer late");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > `E8TC_ADDR_COUNT
      |=> s_axi_rresp == `E8TC_RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_pin;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0]
      && s_axi_awaddr == `E8TC_ADDR_CONTROL |-> ##3 timer_pin_oe == $past(s_axi_wdata[0], 3);
  endproperty
  a_pin: assert property (p_pin) else $error("pin select not applied");
  c_pin: cover property ($rose(timer_pin_oe));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == `E8TC_RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // e8tc_monitor
bind e8tc_top e8tc_monitor #(.ADDR_W(ADDR_W)) e8tc_monitor_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .timer_pin_oe(timer_pin_oe));
`default_nettype wire

// ==== bench/tb_e8tc_top.sv ====
// Self-checking bench for the 8-bit timer control
`timescale 1ns/1ps
`default_nettype none
`include "e8tc_regs.vh"
module tb_e8tc_top;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rdat, rd_v;
  logic [1:0] bresp, rresp, rsp;
  logic awr, wr_r, bv, arr, rv, irq, tout, oe;
  int failures = 0, checks = 0, seed = 32'h7f499215, cyc = 0, t0, ctl_m, hold_m, i;
  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  e8tc_top e8tc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rre), .irq(irq), .timer_out(tout), .timer_pin_oe(oe));
  task end_sim;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    begin
      checks++;
      if (got !== exp)
      begin
        failures++;
        $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
    end
  endtask
  // Valids held until their own ready; answer ready may come late, then holds until the answer
  // A spare edge after each transfer keeps two calls from driving one signal in one time step
  task wr(input logic [11:0] a, input logic [31:0] d);
    begin
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bre <= ($random(seed) & 1) != 0;
      do
      begin
        @(posedge aclk);
        if (awr) awv <= 0;
        if (wr_r) wv <= 0;
        if (bv && !bre) bre <= 1;
      end while (!(bv && bre));
      bre <= 0;
      rsp = bresp;
      @(posedge aclk);
    end
  endtask
  task rd(input logic [11:0] a);
    begin
      ara <= a;
      arv <= 1;
      rre <= ($random(seed) & 1) != 0;
      do
      begin
        @(posedge aclk);
        if (arr) arv <= 0;
        if (rv && !rre) rre <= 1;
      end while (!(rv && rre));
      rre <= 0;
      rd_v = rdat;
      rsp = rresp;
      @(posedge aclk);
    end
  endtask
  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`E8TC_ADDR_CONTROL);
    chk(rd_v, 0, "control reset");
    $display("test reset done");
    for (i = 0; i < 6; i++)
    begin
      hold_m = (i == 0) ? 0 : (i == 1) ? 255 : $random(seed) & 255;
      wr(`E8TC_ADDR_LOW_HOLD, ($random(seed) & 32'hffffff00) | hold_m);
      rd(`E8TC_ADDR_LOW_HOLD);
      chk(rd_v, hold_m, "low hold");
    end
    $display("test hold done");
    for (i = 0; i < 4; i++)
    begin
      ctl_m = (i << 3) | ($random(seed) & 8'h47);
      wr(`E8TC_ADDR_CONTROL, ctl_m);
      chk(oe, ctl_m & 1, "pin select");
      rd(`E8TC_ADDR_CONTROL);
      chk(rd_v, ctl_m, "control fields");
    end
    $display("test fields done");
    // Clearing the flag and enabling in one write keeps software order legal
    wr(`E8TC_ADDR_LOW_HOLD, 8);
    for (i = 0; i < 4; i++)
    begin
      wr(`E8TC_ADDR_CONTROL, 32'he2 | (i << 3));
      t0 = cyc;
      do rd(`E8TC_ADDR_CONTROL); while (!rd_v[5] && cyc - t0 < 200);
      chk(cyc - t0 >= (8 << i) - 2 && cyc - t0 <= (9 << i) + 12, 1, "prescale span");
      rd(`E8TC_ADDR_COUNT);
      chk(rd_v, 0, "oneshot stop");
      chk(tout, 1, "output after expiry");
    end
    rd(`E8TC_ADDR_INT_STAT);
    chk(rd_v, 1, "expiry status");
    chk(irq, 0, "irq masked");
    wr(`E8TC_ADDR_INT_MASK, 1);
    @(posedge aclk);
    chk(irq, 1, "irq raised");
    wr(`E8TC_ADDR_INT_STAT, 1);
    @(posedge aclk);
    chk(irq, 0, "irq cleared");
    $display("test timing done");
    wr(`E8TC_ADDR_CONTROL, 32'h5a);
    rd(`E8TC_ADDR_CONTROL);
    chk(rd_v, 32'h7a, "flag kept on zero");
    wr(`E8TC_ADDR_CONTROL, rd_v | 32'h20);
    rd(`E8TC_ADDR_CONTROL);
    chk(rd_v, 32'h5a, "flag cleared");
    rd(`E8TC_ADDR_COUNT);
    chk(rd_v[8], 1, "restart on clear");
    chk(rd_v[7:0], 8, "restart loads hold");
    chk(tout, 0, "output low on restart");
    wr(`E8TC_ADDR_CONTROL, 32'ha0);
    t0 = cyc;
    do rd(`E8TC_ADDR_CONTROL); while (!rd_v[5] && cyc - t0 < 200);
    rd(`E8TC_ADDR_COUNT);
    chk(rd_v[8], 1, "reload keeps running");
    $display("test flag done");
    rd(12'he00);
    chk(rsp, `E8TC_RESP_SLVERR, "unmapped read");
    chk(rd_v, 0, "unmapped data");
    wr(12'he00, 32'hff);
    chk(rsp, `E8TC_RESP_SLVERR, "unmapped write");
    $display("test unmapped done");
    end_sim();
  end
endmodule // tb_e8tc_top
`default_nettype wire
